/* File: isf_pkg.sv */
// isf_pkg: constants for the interrupt status and pin filter block
// assumes a 32-bit AXI4-Lite register bus and a 125 MHz core clock
package isf_pkg;
  localparam int unsigned ISF_PINS = 7;
  localparam int unsigned ISF_LEVELS = 8;
  // byte addresses
  localparam logic [31:0] ISF_ADDR_WDT_MODE = 32'hFFFFF384;
  localparam logic [31:0] ISF_ADDR_FILT_CLK = 32'hFFFFF3D4;
  localparam logic [31:0] ISF_ADDR_IN_SERV = 32'hFFFFF3E0;
  localparam logic [31:0] ISF_ADDR_PSW = 32'hFFFFF3E4;
  localparam logic [31:0] ISF_ADDR_RISE_EN = 32'hFFFFF3E8;
  localparam logic [31:0] ISF_ADDR_FALL_EN = 32'hFFFFF3EC;
  localparam logic [31:0] ISF_ADDR_REQ_FLAGS = 32'hFFFFF3F0;
  localparam logic [31:0] ISF_ADDR_SAVED_PC = 32'hFFFFF3F4;
  localparam logic [31:0] ISF_ADDR_SAVED_PSW = 32'hFFFFF3F8;
  localparam logic [31:0] ISF_ADDR_CAUSE = 32'hFFFFF3FC;
  // status word fields and reset
  localparam int unsigned ISF_PSW_ID = 5;
  localparam int unsigned ISF_PSW_EP = 6;
  localparam int unsigned ISF_PSW_NP = 7;
  localparam logic [31:0] ISF_PSW_RESET = 32'h00000020;
  // watchdog mode fields
  localparam int unsigned ISF_WDT_RUN = 7;
  localparam int unsigned ISF_WDT_SEL = 4;
  localparam logic [7:0] ISF_WDT_MASK = 8'h90;
  // filter clock select codes
  localparam logic [2:0] ISF_FCLK_MAIN = 3'h0;
  localparam logic [2:0] ISF_FCLK_D64 = 3'h1;
  localparam logic [2:0] ISF_FCLK_D128 = 3'h2;
  localparam logic [2:0] ISF_FCLK_D256 = 3'h3;
  localparam logic [2:0] ISF_FCLK_D512 = 3'h4;
  localparam logic [2:0] ISF_FCLK_D1024 = 3'h5;
  localparam logic [2:0] ISF_FCLK_BAD = 3'h6;
  localparam logic [2:0] ISF_FCLK_SUB = 3'h7;
  localparam int unsigned ISF_SAMPLES = 3;
  // software trap
  localparam logic [15:0] ISF_TRAP_CODE_BASE = 16'h0040;
  localparam logic [31:0] ISF_TRAP_VEC_LO = 32'h00000040;
  localparam logic [31:0] ISF_TRAP_VEC_HI = 32'h00000050;
  localparam int unsigned ISF_TRAP_HI_BIT = 4;
  localparam logic [1:0] ISF_RESP_OKAY = 2'h0;
  localparam logic [1:0] ISF_RESP_SLVERR = 2'h2;
endpackage

/* File: isf_top.sv */
// isf_top: in-service levels, status word flags, pin filters and edge
// select, software trap entry/return, watchdog mode lock
// assumes the core decides acknowledgement and reports it by one-cycle pulses
`timescale 1ns/100ps
// Overview of operation
// - acknowledge sets in-service bit of the request's level; held during service
// - return clears the highest-priority set in-service bit
// - return from nmi or exception leaves in-service bits alone
// - in-service register read only, eight levels, zero after reset
// - status bit 5 blocks maskable acknowledge when 1
// - block instr sets, allow instr clears; return and loads change it
// - nmi and exceptions taken regardless of block flag
// - maskable acknowledge sets block flag
// - blocked request stays pending until flag clears
// - watchdog bit 7 run, bit 4 watchdog mode select
// - once run or select written 1 only reset clears register
// - pins 4 and 5 need three equal main-clock samples
// - three-bit select picks pin-6 sample clock; code 110 prohibited
// - pin-6 filter takes three samples of selected clock
// - sub clock sampling keeps pin 6 alive in standby
// - after clock change filter refills over three sample periods
// - per pin rising and falling enable bits pick the edge
// - after reset no pin detects any edge
// - trap with vector 0 to 1F always raises exception
// - trap saves pc and status, writes cause, sets flags, jumps
// - return with exception flag restores pc and status
// - status bit 6 is set on exception, reads 1 while in progress
// - level 0 highest, level 7 lowest
// - acknowledge clears that source's request flag
module isf_top (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [6:0] ext_irq_pins_i,
  input wire logic sub_clk_i,
  input wire logic ack_i,
  input wire logic [2:0] ack_level_i,
  input wire logic ack_ext_i,
  input wire logic [2:0] ack_pin_i,
  input wire logic mask_block_instr_i,
  input wire logic mask_allow_instr_i,
  input wire logic return_from_handler_i,
  input wire logic [31:0] nmi_return_status_i,
  input wire logic sysreg_load_instr_i,
  input wire logic [31:0] sysreg_data_i,
  input wire logic trap_i,
  input wire logic [4:0] trap_vector_i,
  input wire logic [31:0] trap_return_pc_i,
  output logic [31:0] program_status_word_o,
  output logic [7:0] in_service_levels_o,
  output logic [6:0] request_pending_flag_o,
  output logic ext_request_o,
  output logic pc_load_o,
  output logic [31:0] pc_target_o,
  output logic wdt_run_o,
  output logic wdt_mode_o
);
  logic [31:0] psw_r, psw_nxt;
  logic [7:0] isl_r, isl_nxt;
  logic [31:0] saved_pc_r, saved_psw_r, cause_r;
  logic [7:0] wdt_r;
  logic [2:0] fsel_r;
  logic [6:0] rise_en_r, fall_en_r, req_r, req_nxt;
  logic pc_load_r;
  logic [31:0] pc_target_r;
  logic [9:0] div_r;
  logic [2:0] sub_sync_r;
  logic sub_lvl_r;
  // bus side state
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [31:0] awaddr_r, wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;

  // ---------------- AXI4-Lite slave ----------------
  wire aw_take = s_axi_awvalid & ~aw_held_r & ~bvalid_r;
  wire w_take = s_axi_wvalid & ~w_held_r & ~bvalid_r;
  wire wr_go = aw_held_r & w_held_r & ~bvalid_r;
  wire rd_take = s_axi_arvalid & ~rvalid_r;
  wire wr_wdt = wr_go & (awaddr_r == isf_pkg::ISF_ADDR_WDT_MODE) & wstrb_r[0];
  wire wr_fclk = wr_go & (awaddr_r == isf_pkg::ISF_ADDR_FILT_CLK) & wstrb_r[0];
  wire wr_rise = wr_go & (awaddr_r == isf_pkg::ISF_ADDR_RISE_EN) & wstrb_r[0];
  wire wr_fall = wr_go & (awaddr_r == isf_pkg::ISF_ADDR_FALL_EN) & wstrb_r[0];
  wire wr_req = wr_go & (awaddr_r == isf_pkg::ISF_ADDR_REQ_FLAGS) & wstrb_r[0];
  wire wr_hit = (awaddr_r == isf_pkg::ISF_ADDR_WDT_MODE) | (awaddr_r == isf_pkg::ISF_ADDR_FILT_CLK) |
                (awaddr_r == isf_pkg::ISF_ADDR_RISE_EN) | (awaddr_r == isf_pkg::ISF_ADDR_FALL_EN) |
                (awaddr_r == isf_pkg::ISF_ADDR_REQ_FLAGS);
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      isf_pkg::ISF_ADDR_WDT_MODE: rd_mux = {24'h000000, wdt_r};
      isf_pkg::ISF_ADDR_FILT_CLK: rd_mux = {29'h00000000, fsel_r};
      isf_pkg::ISF_ADDR_IN_SERV: rd_mux = {24'h000000, isl_r};
      isf_pkg::ISF_ADDR_PSW: rd_mux = psw_r;
      isf_pkg::ISF_ADDR_RISE_EN: rd_mux = {25'h0000000, rise_en_r};
      isf_pkg::ISF_ADDR_FALL_EN: rd_mux = {25'h0000000, fall_en_r};
      isf_pkg::ISF_ADDR_REQ_FLAGS: rd_mux = {25'h0000000, req_r};
      isf_pkg::ISF_ADDR_SAVED_PC: rd_mux = saved_pc_r;
      isf_pkg::ISF_ADDR_SAVED_PSW: rd_mux = saved_psw_r;
      isf_pkg::ISF_ADDR_CAUSE: rd_mux = cause_r;
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready = ~w_held_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bresp_r <= isf_pkg::ISF_RESP_OKAY;
      rresp_r <= isf_pkg::ISF_RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? isf_pkg::ISF_RESP_OKAY : isf_pkg::ISF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? isf_pkg::ISF_RESP_OKAY : isf_pkg::ISF_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ---------------- control registers ----------------
  // sticky lock: once either bit is 1 no bus write to the watchdog mode register lands
  wire wdt_locked = |(wdt_r & isf_pkg::ISF_WDT_MASK);
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wdt_r <= 8'h00;
      fsel_r <= isf_pkg::ISF_FCLK_MAIN;
      rise_en_r <= 7'h00;
      fall_en_r <= 7'h00;
    end else begin
      if (wr_wdt && !wdt_locked) begin
        wdt_r <= wdata_r[7:0] & isf_pkg::ISF_WDT_MASK;
      end
      if (wr_fclk) begin
        fsel_r <= wdata_r[2:0];
      end
      if (wr_rise) begin
        rise_en_r <= wdata_r[6:0];
      end
      if (wr_fall) begin
        fall_en_r <= wdata_r[6:0];
      end
    end
  end
  assign wdt_run_o = wdt_r[isf_pkg::ISF_WDT_RUN];
  assign wdt_mode_o = wdt_r[isf_pkg::ISF_WDT_SEL];

  // ---------------- pin-6 sample tick ----------------
  // prohibited code gives no tick, so the filter simply holds
  logic [9:0] div_mask;
  always_comb begin
    case (fsel_r)
      isf_pkg::ISF_FCLK_D64: div_mask = 10'h03F;
      isf_pkg::ISF_FCLK_D128: div_mask = 10'h07F;
      isf_pkg::ISF_FCLK_D256: div_mask = 10'h0FF;
      isf_pkg::ISF_FCLK_D512: div_mask = 10'h1FF;
      isf_pkg::ISF_FCLK_D1024: div_mask = 10'h3FF;
      default: div_mask = 10'h000;
    endcase
  end
  wire sub_tick = (sub_sync_r[1] == sub_sync_r[2]) & sub_sync_r[2] & ~sub_lvl_r;
  wire tick6 = (fsel_r == isf_pkg::ISF_FCLK_SUB) ? sub_tick :
               (fsel_r == isf_pkg::ISF_FCLK_BAD) ? 1'b0 : ((div_r & div_mask) == div_mask);
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      div_r <= 10'h000;
      sub_sync_r <= 3'h0;
      sub_lvl_r <= 1'b0;
    end else begin
      div_r <= div_r + 10'h001;
      sub_sync_r <= {sub_sync_r[1:0], sub_clk_i};
      if (sub_sync_r[1] == sub_sync_r[2]) begin
        sub_lvl_r <= sub_sync_r[2];
      end
    end
  end

  // ---------------- pin filters and edge select ----------------
  logic [6:0] edge_hit;
  logic [6:0] pin_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < isf_pkg::ISF_PINS; gi++) begin : g_pin
      logic [2:0] sync_r;
      logic [isf_pkg::ISF_SAMPLES-1:0] hist_r;
      logic lvl_r;
      // pin 6 runs at the selected rate, the others on every main clock
      wire tick = (gi == isf_pkg::ISF_PINS - 1) ? tick6 : 1'b1;
      wire agree = (sync_r[1] == sync_r[2]);
      wire all_hi = &hist_r;
      wire all_lo = ~|hist_r;
      wire accept = (all_hi & ~lvl_r) | (all_lo & lvl_r);
      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          sync_r <= 3'h0;
          hist_r <= '0;
          lvl_r <= 1'b0;
        end else begin
          sync_r <= {sync_r[1:0], ext_irq_pins_i[gi]};
          // history refills after a rate change; a stale edge may still fire
          if (tick && agree) begin
            hist_r <= {hist_r[isf_pkg::ISF_SAMPLES-2:0], sync_r[2]};
          end
          if (accept) begin
            lvl_r <= all_hi;
          end
        end
      end
      assign edge_hit[gi] = accept & ((all_hi & rise_en_r[gi]) | (all_lo & fall_en_r[gi]));
      assign pin_lvl[gi] = lvl_r;
    end
  endgenerate

  // ---------------- request flags ----------------
  wire [6:0] ack_clr = (ack_i & ack_ext_i) ? (7'h01 << ack_pin_i) : 7'h00;
  wire [6:0] sw_clr = wr_req ? wdata_r[6:0] : 7'h00;
  // set beats either clear in the same cycle
  assign req_nxt = (req_r & ~ack_clr & ~sw_clr) | edge_hit;
  assign request_pending_flag_o = req_r;
  assign ext_request_o = (|req_r) & ~psw_r[isf_pkg::ISF_PSW_ID] & ~psw_r[isf_pkg::ISF_PSW_NP];

  // ---------------- in-service levels ----------------
  logic [7:0] top_bit;
  always_comb begin
    top_bit = 8'h00;
    for (int k = isf_pkg::ISF_LEVELS - 1; k >= 0; k--) begin
      if (isl_r[k]) begin
        top_bit = 8'h01 << k;
      end
    end
  end
  wire return_from_handler_plain = return_from_handler_i & ~psw_r[isf_pkg::ISF_PSW_EP] & ~psw_r[isf_pkg::ISF_PSW_NP];
  always_comb begin
    isl_nxt = isl_r;
    if (return_from_handler_plain) begin
      isl_nxt = isl_nxt & ~top_bit;
    end
    if (ack_i) begin
      isl_nxt = isl_nxt | (8'h01 << ack_level_i);
    end
  end

  // ---------------- status word ----------------
  always_comb begin
    psw_nxt = psw_r;
    if (mask_block_instr_i) begin
      psw_nxt[isf_pkg::ISF_PSW_ID] = 1'b1;
    end
    if (mask_allow_instr_i) begin
      psw_nxt[isf_pkg::ISF_PSW_ID] = 1'b0;
    end
    if (sysreg_load_instr_i) begin
      psw_nxt = sysreg_data_i;
    end
    if (return_from_handler_i) begin
      psw_nxt = psw_r[isf_pkg::ISF_PSW_EP] ? saved_psw_r : nmi_return_status_i;
    end
    if (ack_i) begin
      psw_nxt[isf_pkg::ISF_PSW_ID] = 1'b1;
    end
    if (trap_i) begin
      psw_nxt[isf_pkg::ISF_PSW_EP] = 1'b1;
      psw_nxt[isf_pkg::ISF_PSW_ID] = 1'b1;
    end
  end
  wire [31:0] trap_target = trap_vector_i[isf_pkg::ISF_TRAP_HI_BIT] ? isf_pkg::ISF_TRAP_VEC_HI :
                            isf_pkg::ISF_TRAP_VEC_LO;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      psw_r <= isf_pkg::ISF_PSW_RESET;
      isl_r <= 8'h00;
      req_r <= 7'h00;
      saved_pc_r <= 32'h00000000;
      saved_psw_r <= 32'h00000000;
      cause_r <= 32'h00000000;
      pc_load_r <= 1'b0;
      pc_target_r <= 32'h00000000;
    end else begin
      psw_r <= psw_nxt;
      isl_r <= isl_nxt;
      req_r <= req_nxt;
      pc_load_r <= trap_i | (return_from_handler_i & psw_r[isf_pkg::ISF_PSW_EP]);
      if (trap_i) begin
        saved_pc_r <= trap_return_pc_i;
        saved_psw_r <= psw_r;
        cause_r <= {cause_r[31:16], isf_pkg::ISF_TRAP_CODE_BASE | {11'h000, trap_vector_i}};
        pc_target_r <= trap_target;
      end else if (return_from_handler_i && psw_r[isf_pkg::ISF_PSW_EP]) begin
        pc_target_r <= saved_pc_r;
      end
    end
  end
  assign program_status_word_o = psw_r;
  assign in_service_levels_o = isl_r;
  assign pc_load_o = pc_load_r;
  assign pc_target_o = pc_target_r;

  // ---------------- checks ----------------
  property p_ack_sets_level;
    @(posedge core_clk_i) disable iff (!reset_n_i) ack_i |=> isl_r[$past(ack_level_i)];
  endproperty
  a_ack_sets_level: assert property (p_ack_sets_level) else $error("ack level bit not set");
  property p_return_from_handler_clears_top;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (return_from_handler_plain && !ack_i && isl_r != 8'h00) |=> ($countones($past(isl_r)) - $countones(isl_r) == 1);
  endproperty
  a_return_from_handler_clears_top: assert property (p_return_from_handler_clears_top) else $error("return did not clear one level");
  property p_return_from_handler_keep;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (return_from_handler_i && (psw_r[isf_pkg::ISF_PSW_EP] || psw_r[isf_pkg::ISF_PSW_NP]) && !ack_i)
      |=> isl_r == $past(isl_r);
  endproperty
  a_return_from_handler_keep: assert property (p_return_from_handler_keep) else $error("levels changed on exception return");
  property p_ack_blocks;
    @(posedge core_clk_i) disable iff (!reset_n_i) ack_i |=> psw_r[isf_pkg::ISF_PSW_ID];
  endproperty
  a_ack_blocks: assert property (p_ack_blocks) else $error("block flag not set on ack");
  property p_wdt_lock;
    @(posedge core_clk_i) disable iff (!reset_n_i) wdt_locked |=> wdt_r == $past(wdt_r);
  endproperty
  a_wdt_lock: assert property (p_wdt_lock) else $error("locked watchdog mode changed");
  property p_trap_entry;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      trap_i |=> pc_load_o && psw_r[isf_pkg::ISF_PSW_EP] && psw_r[isf_pkg::ISF_PSW_ID]
              && saved_pc_r == $past(trap_return_pc_i) && pc_target_o == $past(trap_target);
  endproperty
  a_trap_entry: assert property (p_trap_entry) else $error("trap entry incomplete");
  property p_no_edge_disabled;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (rise_en_r == 7'h00 && fall_en_r == 7'h00) |-> edge_hit == 7'h00;
  endproperty
  a_no_edge_disabled: assert property (p_no_edge_disabled) else $error("edge with none enabled");
  // history is filled from the samples two to four edges back
  wire sync_hi4 = g_pin[4].sync_r[2];
  property p_filter_three;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(pin_lvl[4]) |-> $past(sync_hi4, 2) && $past(sync_hi4, 3) && $past(sync_hi4, 4);
  endproperty
  a_filter_three: assert property (p_filter_three) else $error("pin 4 accepted short pulse");
  property p_pending_held;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (req_r[0] && !ack_clr[0] && !sw_clr[0]) |=> req_r[0];
  endproperty
  a_pending_held: assert property (p_pending_held) else $error("pending request lost");
  c_trap: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) trap_i ##1 pc_load_o);
  c_nest: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) $countones(isl_r) == 2);
  c_pin6: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) edge_hit[6]);
endmodule

/* File: isf_core_model.sv */
// isf_core_model: core pipeline and interrupt pins facing isf_top
// assumes one caller at a time; strobes last one core clock
`timescale 1ns/100ps
module isf_core_model (
  input wire logic core_clk_i,
  output logic [6:0] ext_pins_o,
  output logic sub_clk_o,
  output logic ack_o,
  output logic [2:0] ack_level_o,
  output logic ack_ext_o,
  output logic [2:0] ack_pin_o,
  output logic block_o,
  output logic allow_o,
  output logic ret_o,
  output logic [31:0] ret_status_o,
  output logic load_o,
  output logic [31:0] load_data_o,
  output logic trap_o,
  output logic [4:0] trap_vec_o,
  output logic [31:0] trap_pc_o
);
  initial begin
    {ext_pins_o, sub_clk_o, ack_o, ack_level_o, ack_ext_o, ack_pin_o, block_o, allow_o, ret_o} = '0;
    {ret_status_o, load_o, load_data_o, trap_o, trap_vec_o, trap_pc_o} = '0;
  end
  // k: 0 ack, 1 block, 2 allow, 3 return, 4 load, 5 trap
  task issue(input int k, input logic [31:0] a, input logic [31:0] b);
    @(posedge core_clk_i);
    case (k)
      0: {ack_o, ack_level_o, ack_ext_o, ack_pin_o} <= {1'b1, a[2:0], b[3:0]};
      1: block_o <= 1'b1;
      2: allow_o <= 1'b1;
      3: {ret_o, ret_status_o} <= {1'b1, b};
      4: {load_o, load_data_o} <= {1'b1, b};
      default: {trap_o, trap_vec_o, trap_pc_o} <= {1'b1, a[4:0], b};
    endcase
    @(posedge core_clk_i);
    {ack_o, block_o, allow_o, ret_o, load_o, trap_o} <= 6'h00;
    // released ack level, ack pin, load data and trap vector payloads scrambled so stale values are never relied on
    {ack_level_o, ack_pin_o, load_data_o, trap_vec_o} <= ~{ack_level_o, ack_pin_o, load_data_o, trap_vec_o};
  endtask
  task pins(input logic [6:0] v);
    @(posedge core_clk_i);
    ext_pins_o <= v;
  endtask
  // sub clock runs only while pin 6 traffic is under test
  task sub_ticks(input int n);
    repeat (2 * n) begin
      repeat (4) @(posedge core_clk_i);
      sub_clk_o <= ~sub_clk_o;
    end
  endtask
endmodule

/* File: isf_top_bench.sv */
// isf_top_bench: register bus and core event tests of isf_top
// assumes isf_core_model stands in for the core and the pins
`timescale 1ns/100ps
module isf_top_bench;
  logic core_clk_i, reset_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, nmi_return_status_i, sysreg_data_i;
  logic [31:0] trap_return_pc_i, program_status_word_o, pc_target_o, l;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sub_clk_i, ack_i, ack_ext_i;
  logic [6:0] ext_irq_pins_i, request_pending_flag_o;
  logic [7:0] in_service_levels_o;
  logic [2:0] ack_level_i, ack_pin_i;
  logic [4:0] trap_vector_i;
  logic mask_block_instr_i, mask_allow_instr_i, return_from_handler_i, sysreg_load_instr_i, trap_i;
  logic ext_request_o, pc_load_o, wdt_run_o, wdt_mode_o;
  int fails, checked, i;
  isf_top u_dut (.core_clk_i, .reset_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_pins_i, .sub_clk_i, .ack_i,
    .ack_level_i, .ack_ext_i, .ack_pin_i, .mask_block_instr_i, .mask_allow_instr_i, .return_from_handler_i,
    .nmi_return_status_i, .sysreg_load_instr_i, .sysreg_data_i, .trap_i, .trap_vector_i, .trap_return_pc_i,
    .program_status_word_o, .in_service_levels_o, .request_pending_flag_o, .ext_request_o, .pc_load_o,
    .pc_target_o, .wdt_run_o, .wdt_mode_o);
  isf_core_model u_core (.core_clk_i, .ext_pins_o(ext_irq_pins_i), .sub_clk_o(sub_clk_i), .ack_o(ack_i),
    .ack_level_o(ack_level_i), .ack_ext_o(ack_ext_i), .ack_pin_o(ack_pin_i), .block_o(mask_block_instr_i),
    .allow_o(mask_allow_instr_i), .ret_o(return_from_handler_i), .ret_status_o(nmi_return_status_i),
    .load_o(sysreg_load_instr_i), .load_data_o(sysreg_data_i), .trap_o(trap_i), .trap_vec_o(trap_vector_i),
    .trap_pc_o(trap_return_pc_i));
  always #4 core_clk_i = ~core_clk_i;
  task stop_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge core_clk_i);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    if (n >= 40) fails++;
    if (n >= 40) stop_test();
    chk("bresp", er, s_axi_bresp);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge core_clk_i);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    if (n >= 40) fails++;
    if (n >= 40) stop_test();
    chk("rresp", er, s_axi_rresp);
    if (er == isf_pkg::ISF_RESP_OKAY) chk("rdata", e, s_axi_rdata);
  endtask
  task wflag(input int p, input int lim);
    for (int n = 0; n < lim && request_pending_flag_o[p] !== 1'b1; n++) @(posedge core_clk_i);
    if (request_pending_flag_o[p] !== 1'b1) fails++;
    #1;
  endtask
  task rst();
    reset_n_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
  endtask
  initial begin
    {core_clk_i, reset_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, fails, checked} = '0;
    s_axi_wstrb = 4'hF;
    rst();
    rd(isf_pkg::ISF_ADDR_IN_SERV, 32'h0, isf_pkg::ISF_RESP_OKAY);
    rd(isf_pkg::ISF_ADDR_PSW, 32'h20, isf_pkg::ISF_RESP_OKAY);
    rd(isf_pkg::ISF_ADDR_RISE_EN, 32'h0, isf_pkg::ISF_RESP_OKAY);
    rd(isf_pkg::ISF_ADDR_FALL_EN, 32'h0, isf_pkg::ISF_RESP_OKAY);
    rd(32'hFFFFF000, 32'h0, isf_pkg::ISF_RESP_SLVERR);
    wr(isf_pkg::ISF_ADDR_IN_SERV, 32'hFF, isf_pkg::ISF_RESP_SLVERR);
    rd(isf_pkg::ISF_ADDR_IN_SERV, 32'h0, isf_pkg::ISF_RESP_OKAY);
    $display("test reset values done");
    s_axi_wstrb <= 4'h0;
    wr(isf_pkg::ISF_ADDR_WDT_MODE, 32'h90, isf_pkg::ISF_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(isf_pkg::ISF_ADDR_WDT_MODE, 32'h0, isf_pkg::ISF_RESP_OKAY);
    wr(isf_pkg::ISF_ADDR_WDT_MODE, 32'h10, isf_pkg::ISF_RESP_OKAY);
    wr(isf_pkg::ISF_ADDR_WDT_MODE, 32'h80, isf_pkg::ISF_RESP_OKAY);
    rd(isf_pkg::ISF_ADDR_WDT_MODE, 32'h10, isf_pkg::ISF_RESP_OKAY);
    chk("wdt_bits", 2'h1, {wdt_run_o, wdt_mode_o});
    rst();
    rd(isf_pkg::ISF_ADDR_WDT_MODE, 32'h0, isf_pkg::ISF_RESP_OKAY);
    wr(isf_pkg::ISF_ADDR_WDT_MODE, 32'hFF, isf_pkg::ISF_RESP_OKAY);
    wr(isf_pkg::ISF_ADDR_WDT_MODE, 32'h0, isf_pkg::ISF_RESP_OKAY);
    rd(isf_pkg::ISF_ADDR_WDT_MODE, 32'h90, isf_pkg::ISF_RESP_OKAY);
    chk("wdt_bits", 2'h3, {wdt_run_o, wdt_mode_o});
    $display("test watchdog lock done");
    for (i = 0; i < 9; i++) begin
      if (i == 6) continue;
      wr(isf_pkg::ISF_ADDR_FILT_CLK, i % 8, isf_pkg::ISF_RESP_OKAY);
      rd(isf_pkg::ISF_ADDR_FILT_CLK, i % 8, isf_pkg::ISF_RESP_OKAY);
    end
    $display("test filter select done");
    u_core.pins(7'h01);
    repeat (16) @(posedge core_clk_i);
    chk("flags", 7'h00, request_pending_flag_o);
    wr(isf_pkg::ISF_ADDR_RISE_EN, 32'h10, isf_pkg::ISF_RESP_OKAY);
    wr(isf_pkg::ISF_ADDR_FALL_EN, 32'h20, isf_pkg::ISF_RESP_OKAY);
    u_core.pins(7'h11);
    u_core.pins(7'h01);
    repeat (16) @(posedge core_clk_i);
    chk("flags", 7'h00, request_pending_flag_o);
    u_core.pins(7'h30);
    wflag(4, 16);
    chk("flags", 7'h10, request_pending_flag_o);
    u_core.pins(7'h10);
    wflag(5, 16);
    chk("flags", 7'h30, request_pending_flag_o);
    chk("ext_req", 1'b0, ext_request_o);
    u_core.issue(2, 0, 0);
    #1;
    chk("psw", 32'h0, program_status_word_o);
    chk("ext_req", 1'b1, ext_request_o);
    u_core.issue(0, 3, 32'hC);
    #1;
    chk("in_serv", 8'h08, in_service_levels_o);
    chk("flags", 7'h20, request_pending_flag_o);
    chk("psw", 32'h20, program_status_word_o);
    rd(isf_pkg::ISF_ADDR_REQ_FLAGS, 32'h20, isf_pkg::ISF_RESP_OKAY);
    wr(isf_pkg::ISF_ADDR_REQ_FLAGS, 32'h20, isf_pkg::ISF_RESP_OKAY);
    rd(isf_pkg::ISF_ADDR_REQ_FLAGS, 32'h0, isf_pkg::ISF_RESP_OKAY);
    u_core.issue(2, 0, 0);
    u_core.issue(0, 1, 0);
    #1;
    chk("in_serv", 8'h0A, in_service_levels_o);
    u_core.issue(3, 0, 32'h1);
    #1;
    chk("in_serv", 8'h08, in_service_levels_o);
    chk("psw", 32'h1, program_status_word_o);
    u_core.issue(1, 0, 0);
    #1;
    chk("psw", 32'h21, program_status_word_o);
    $display("test pins and acknowledge done");
    for (i = 0; i < 2; i++) begin
      l = i ? 32'h0 : 32'h20;
      u_core.issue(4, 0, l);
      u_core.issue(5, i ? 32'h13 : 32'h05, 32'h1000 + i);
      #1;
      chk("pc_load", 1'b1, pc_load_o);
      chk("pc_target", i ? 32'h50 : 32'h40, pc_target_o);
      chk("psw", l | 32'h60, program_status_word_o);
      rd(isf_pkg::ISF_ADDR_SAVED_PC, 32'h1000 + i, isf_pkg::ISF_RESP_OKAY);
      rd(isf_pkg::ISF_ADDR_SAVED_PSW, l, isf_pkg::ISF_RESP_OKAY);
      rd(isf_pkg::ISF_ADDR_CAUSE, i ? 32'h53 : 32'h45, isf_pkg::ISF_RESP_OKAY);
      u_core.issue(3, 0, 0);
      #1;
      chk("pc_target", 32'h1000 + i, pc_target_o);
      chk("psw", l, program_status_word_o);
      chk("in_serv", 8'h08, in_service_levels_o);
    end
    $display("test trap done");
    wr(isf_pkg::ISF_ADDR_FILT_CLK, 32'h1, isf_pkg::ISF_RESP_OKAY);
    wr(isf_pkg::ISF_ADDR_RISE_EN, 32'h40, isf_pkg::ISF_RESP_OKAY);
    repeat (250) @(posedge core_clk_i);
    wr(isf_pkg::ISF_ADDR_REQ_FLAGS, 32'h7F, isf_pkg::ISF_RESP_OKAY);
    u_core.pins(7'h40);
    repeat (20) @(posedge core_clk_i);
    chk("flags", 7'h00, request_pending_flag_o);
    wflag(6, 400);
    chk("flags", 7'h40, request_pending_flag_o);
    wr(isf_pkg::ISF_ADDR_FILT_CLK, 32'h7, isf_pkg::ISF_RESP_OKAY);
    u_core.pins(7'h00);
    u_core.sub_ticks(4);
    wr(isf_pkg::ISF_ADDR_REQ_FLAGS, 32'h7F, isf_pkg::ISF_RESP_OKAY);
    u_core.pins(7'h40);
    u_core.sub_ticks(6);
    chk("flags", 7'h40, request_pending_flag_o);
    $display("test pin six filter done");
    stop_test();
  end
endmodule
